// ==== shared/link_cfg_if.sv ====
// Register port between the link configuration controller and the device.
`timescale 1ns/10ps
interface link_cfg_if;
    logic        req;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        ack;
    logic [7:0]  rdata;
    modport device (input req, input wr, input addr, input wdata, output ack, output rdata);
    modport host   (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface

// ==== shared/link_cfg_pkg.sv ====
// Shared constants and types for the serial link configuration registers.
package link_cfg_pkg;
    // Device register indices as printed; byte address on the device port is the index itself.
    localparam logic [11:0] ADDR_LINK_MODE_SELECT  = 12'h0201;
    localparam logic [11:0] ADDR_FRAMES_PER_MF_M1  = 12'h0202;
    localparam logic [11:0] ADDR_SOFT_SYNC_REQUEST = 12'h0203;
    localparam logic [11:0] ADDR_LINK_CONTROL      = 12'h0204;
    // Reset values.
    localparam logic [7:0] RST_LINK_MODE_SELECT  = 8'h02;
    localparam logic [7:0] RST_FRAMES_PER_MF_M1  = 8'h1f;
    localparam logic [7:0] RST_SOFT_SYNC_REQUEST = 8'h01;
    localparam logic [7:0] RST_LINK_CONTROL      = 8'h03;
    // Link control field positions.
    localparam int CTL_SCRAMBLER_BIT  = 0;
    localparam int CTL_FORMAT_BIT     = 1;
    localparam int CTL_SYNC_SRC_LO    = 2;
    localparam int CTL_UPPER_LANE_BIT = 4;
    localparam logic [7:0] CTL_WRITE_MASK = 8'h1f;
    // Sync source encodings.
    localparam logic [1:0] SYNC_SRC_PRIMARY   = 2'h0;
    localparam logic [1:0] SYNC_SRC_TIMESTAMP = 2'h1;
    localparam logic [1:0] SYNC_SRC_NONE      = 2'h2;
    // Effective K in 64b/66b modes is 256*E/F.
    localparam int K_64B66B_SCALE = 256;
    // Controller APB register byte addresses.
    localparam logic [11:0] APB_CTRL     = 12'h0000;
    localparam logic [11:0] APB_ADDR     = 12'h0004;
    localparam logic [11:0] APB_WDATA    = 12'h0008;
    localparam logic [11:0] APB_STATUS   = 12'h000c;
    localparam logic [11:0] APB_MODE_OK  = 12'h0010;
    // Controller command encoding in the control register.
    localparam int CMD_GO_BIT    = 0;
    localparam int CMD_WRITE_BIT = 1;
    typedef enum logic [1:0] {
        CTL_IDLE,
        CTL_REQ,
        CTL_WAIT
    } ctl_state_t;
endpackage

// ==== src/link_cfg_device.sv ====
// Serial link configuration register bank, the device end.
//
// Overview of operation
// - Mode changes only with link and calibration disabled.
// - Mode register selects link mode, resets two.
// - Permission input restricts which modes are taken.
// - Software writes frame count minus one.
// - Frames register resets to 31.
// - 64b/66b modes derive K as 256*E/F.
// - Frames register changes only with link disabled.
// - Writing zero raises sync; resets to one.
// - Software sync works with any source.
// - Lower lanes used when upper select clear.
// - Upper lanes used when upper select set.
// - Upper lanes only for modes of four lanes or fewer; the code leaves this to software.
// - Source zero selects primary sync pin.
// - Source one selects timestamp pin.
// - Source two ignores all sync pins.
// - Format bit: offset binary or two's complement.
// - Scrambler bit enables 8b/10b scrambling.
// - 64b/66b modes always scramble.
// - Scrambler changes only with link disabled.
// - Disabled link held in reset, lanes down.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
module link_cfg_device
    import link_cfg_pkg::*;
#(
    parameter int MODE_COUNT = 256,
    parameter int LANES      = 8
)
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    link_cfg_if.device                 cfg,
    input  wire logic [MODE_COUNT-1:0] mode_allowed,
    input  wire logic [MODE_COUNT-1:0] mode_is_64b66b,
    input  wire logic [7:0]            mode_e,
    input  wire logic [7:0]            mode_f,
    input  wire logic                  link_enable,
    input  wire logic                  primary_sync_pin_n,
    input  wire logic                  timestamp_pin_n,
    output logic [7:0]                 link_mode_select,
    output logic [8:0]                 frames_per_multiframe,
    output logic                       sample_format,
    output logic                       scramble_active,
    output logic                       sync_request,
    output logic [LANES-1:0]           link_a_lane_on,
    output logic [LANES-1:0]           link_b_lane_on,
    output logic                       link_held_reset
);
    // Stored register copies; the mode register is itself an output.
    logic [7:0]  frames_per_multiframe_m1;
    logic [7:0]  soft_sync_request;
    logic [7:0]  link_control;
    logic        wr_hit;
    logic        hit_mode;
    logic        hit_frames;
    logic        hit_sync;
    logic        hit_control;
    logic [7:0]  next_rdata;
    logic [15:0] k_64b66b;

    // True when the mode uses the 64b/66b link layer; K and scrambling both depend on it.
    function automatic logic wide_mode(input logic [MODE_COUNT-1:0] table_bits, input logic [7:0] mode);
        return table_bits[mode];
    endfunction

    // A lane is on when the link is up and the lane sits in the selected half.
    function automatic logic lane_in_use(input int idx, input logic upper_half, input logic enabled);
        return enabled && ((idx >= LANES / 2) == upper_half);
    endfunction

    // A write is taken once, on the edge before the acknowledge pulse.
    assign wr_hit      = cfg.req && cfg.wr && !cfg.ack;
    assign hit_mode    = wr_hit && cfg.addr == ADDR_LINK_MODE_SELECT;
    assign hit_frames  = wr_hit && cfg.addr == ADDR_FRAMES_PER_MF_M1;
    assign hit_sync    = wr_hit && cfg.addr == ADDR_SOFT_SYNC_REQUEST;
    assign hit_control = wr_hit && cfg.addr == ADDR_LINK_CONTROL;

    // Mode register; a refused mode keeps the old value and is still acknowledged.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_mode_select <= RST_LINK_MODE_SELECT;
        end else if (hit_mode && mode_allowed[cfg.wdata]) begin
            link_mode_select <= cfg.wdata;
        end
    end

    // Frame count register; software keeps it legal for the mode.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frames_per_multiframe_m1 <= RST_FRAMES_PER_MF_M1;
        end else if (hit_frames) begin
            frames_per_multiframe_m1 <= cfg.wdata;
        end
    end

    // Software sync bit; only bit 0 is stored, so reserved bits read zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            soft_sync_request <= RST_SOFT_SYNC_REQUEST;
        end else if (hit_sync) begin
            soft_sync_request <= {7'h00, cfg.wdata[0]};
        end
    end

    // Link control; reserved bits are masked off on the way in.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_control <= RST_LINK_CONTROL;
        end else if (hit_control) begin
            link_control <= cfg.wdata & CTL_WRITE_MASK;
        end
    end

    // One-cycle answer to every request; unmapped reads return zero.
    always_comb begin
        unique case (cfg.addr)
            ADDR_LINK_MODE_SELECT:  next_rdata = link_mode_select;
            ADDR_FRAMES_PER_MF_M1:  next_rdata = frames_per_multiframe_m1;
            ADDR_SOFT_SYNC_REQUEST: next_rdata = soft_sync_request;
            ADDR_LINK_CONTROL:      next_rdata = link_control;
            default:                next_rdata = 8'h00;
        endcase
    end

    // Acknowledge pulses once per request; the host drops req on the acknowledge edge.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg.ack <= 1'b0;
        end else begin
            cfg.ack <= cfg.req && !cfg.ack;
        end
    end

    // Read data is refreshed every cycle, so it is valid together with the acknowledge.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg.rdata <= 8'h00;
        end else begin
            cfg.rdata <= next_rdata;
        end
    end

    // Frame count: 64b/66b modes ignore the register and derive K from E and F.
    // A zero F would divide by zero, so it yields zero instead of an unknown.
    assign k_64b66b = (mode_f == 8'h00) ? 16'h0000
                    : 16'((K_64B66B_SCALE * int'(mode_e)) / int'(mode_f));
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frames_per_multiframe <= 9'h000;
        end else if (!link_enable) begin
            frames_per_multiframe <= 9'h000;
        end else if (wide_mode(mode_is_64b66b, link_mode_select)) begin
            frames_per_multiframe <= k_64b66b[8:0];
        end else begin
            frames_per_multiframe <= 9'(frames_per_multiframe_m1) + 9'h001;
        end
    end

    // Sample format follows its control bit directly.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sample_format <= 1'b0;
        end else begin
            sample_format <= link_control[CTL_FORMAT_BIT];
        end
    end

    // Scrambling: forced on in 64b/66b modes, off while the link is disabled.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scramble_active <= 1'b0;
        end else begin
            scramble_active <= link_enable && (wide_mode(mode_is_64b66b, link_mode_select)
                               || link_control[CTL_SCRAMBLER_BIT]);
        end
    end

    // The link block stays in reset whenever the link is disabled.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_held_reset <= 1'b1;
        end else begin
            link_held_reset <= !link_enable;
        end
    end

    // Lane power: lower half or upper half, nothing while disabled.
    // Modes wider than half the lanes must not pick the upper half; that is left to software.
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    link_a_lane_on[g] <= 1'b0;
                    link_b_lane_on[g] <= 1'b0;
                end else begin
                    link_a_lane_on[g] <= lane_in_use(g, link_control[CTL_UPPER_LANE_BIT], link_enable);
                    link_b_lane_on[g] <= lane_in_use(g, link_control[CTL_UPPER_LANE_BIT], link_enable);
                end
            end
        end
    endgenerate

    sync_select u_sync_select (
        .clk                (clk),
        .sys_rst            (sys_rst),
        .sync_source        (link_control[CTL_SYNC_SRC_LO +: 2]),
        .soft_sync_request  (soft_sync_request[0]),
        .primary_sync_pin_n (primary_sync_pin_n),
        .timestamp_pin_n    (timestamp_pin_n),
        .sync_request       (sync_request)
    );
endmodule

// ==== src/link_cfg_host.sv ====
// APB-driven controller that reads and writes the device configuration registers.
`timescale 1ns/10ps
module link_cfg_host
    import link_cfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_enable,
    input  wire logic        calibration_enable,
    link_cfg_if.host         cfg
);
    ctl_state_t  state;
    logic [11:0] dev_addr;
    logic [7:0]  dev_wdata;
    logic        dev_wr;
    logic [7:0]  last_rdata;
    logic        error_flag;
    logic        apb_wr;
    logic        go;
    logic        guarded;
    logic [31:0] next_prdata;

    // A write lands only on the edge at which the master sees pready high.
    assign apb_wr = psel && penable && pwrite && pready;
    assign go     = apb_wr && paddr == APB_CTRL && pwdata[CMD_GO_BIT] && state == CTL_IDLE;
    // Mode needs link and calibration off; other config registers except soft sync need link off.
    assign guarded = (dev_addr == ADDR_LINK_MODE_SELECT) ? (link_enable || calibration_enable)
                   : (dev_addr != ADDR_SOFT_SYNC_REQUEST) && link_enable;

    // Command setup registers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dev_addr  <= 12'h000;
            dev_wdata <= 8'h00;
            dev_wr    <= 1'b0;
        end else if (apb_wr && state == CTL_IDLE) begin
            if (paddr == APB_ADDR)  dev_addr  <= pwdata[11:0];
            if (paddr == APB_WDATA) dev_wdata <= pwdata[7:0];
            if (paddr == APB_CTRL)  dev_wr    <= pwdata[CMD_WRITE_BIT];
        end
    end

    // Transfer sequencer; a write blocked by the enable guard sets the error flag.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state      <= CTL_IDLE;
            cfg.req    <= 1'b0;
            cfg.wr     <= 1'b0;
            cfg.addr   <= 12'h000;
            cfg.wdata  <= 8'h00;
            last_rdata <= 8'h00;
            error_flag <= 1'b0;
        end else begin
            unique case (state)
                CTL_IDLE: if (go) begin
                    state <= CTL_REQ;
                end
                CTL_REQ: begin
                    if (dev_wr && guarded) begin
                        error_flag <= 1'b1;
                        state      <= CTL_IDLE;
                    end else begin
                        error_flag <= 1'b0;
                        cfg.req    <= 1'b1;
                        cfg.wr     <= dev_wr;
                        cfg.addr   <= dev_addr;
                        cfg.wdata  <= dev_wdata;
                        state      <= CTL_WAIT;
                    end
                end
                CTL_WAIT: if (cfg.ack) begin
                    cfg.req    <= 1'b0;
                    last_rdata <= cfg.rdata;
                    state      <= CTL_IDLE;
                end
            endcase
        end
    end

    // APB read mux; unmapped offsets read zero with no error.
    always_comb begin
        unique case (paddr)
            APB_ADDR:    next_prdata = {20'h0_0000, dev_addr};
            APB_WDATA:   next_prdata = {24'h00_0000, dev_wdata};
            APB_STATUS:  next_prdata = {22'h00_0000, error_flag, state != CTL_IDLE, last_rdata};
            APB_MODE_OK: next_prdata = {30'h0000_0000, calibration_enable, link_enable};
            default:     next_prdata = 32'h0000_0000;
        endcase
    end

    // Every access completes in its first access-phase cycle plus one.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            prdata  <= next_prdata;
            pslverr <= 1'b0;
        end
    end
endmodule

// ==== src/sync_select.sv ====
// Sync source selection and request combining.
`timescale 1ns/10ps
module sync_select
    import link_cfg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [1:0] sync_source,
    input  wire logic       soft_sync_request,
    input  wire logic       primary_sync_pin_n,
    input  wire logic       timestamp_pin_n,
    output logic            sync_request
);
    logic pin_active;

    // Pins are active low; value 2 or above ignores both pins.
    always_comb begin
        unique case (sync_source)
            SYNC_SRC_PRIMARY:   pin_active = !primary_sync_pin_n;
            SYNC_SRC_TIMESTAMP: pin_active = !timestamp_pin_n;
            default:            pin_active = 1'b0;
        endcase
    end

    // Software request always counts; a stuck pin keeps the request up only while that pin is selected.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_request <= 1'b0;
        end else begin
            sync_request <= pin_active || !soft_sync_request;
        end
    end
endmodule

// ==== testbench/link_cfg_checker.sv ====
// Concurrent checks on the register port between the link controller and the device.
`timescale 1ns/10ps
module link_cfg_checker
    import link_cfg_pkg::*;
(
    input wire logic         clk,
    input wire logic         sys_rst,
    input wire logic         req,
    input wire logic         wr,
    input wire logic [11:0]  addr,
    input wire logic [7:0]   wdata,
    input wire logic         ack,
    input wire logic [7:0]   rdata,
    input wire logic         link_enable,
    input wire logic [255:0] mode_allowed,
    input wire logic [7:0]   link_mode_select,
    input wire logic [8:0]   frames_per_multiframe,
    input wire logic [7:0]   link_a_lane_on,
    input wire logic [7:0]   link_b_lane_on,
    input wire logic         link_held_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // A request is taken, answered by a one-cycle ack, then released.
    sequence s_taken; req && !ack; endsequence
    sequence s_answer; ack ##1 (!ack && !req); endsequence
    property p_answer; s_taken |=> s_answer; endproperty
    property p_hold; s_taken |=> $stable(addr) && $stable(wr) && $stable(wdata); endproperty
    property p_leave_reset; $fell(sys_rst) |-> !req && !ack && link_held_reset; endproperty
    property p_disabled; !link_enable |=> link_held_reset && frames_per_multiframe == 9'h000; endproperty
    // Lane outputs settle one register stage after enable; three enabled cycles leave one cycle of margin.
    property p_lanes;
        link_enable [*3] |-> link_a_lane_on == link_b_lane_on && (link_a_lane_on == 8'h0f || link_a_lane_on == 8'hf0);
    endproperty
    property p_unmapped;
        ack && !wr && (addr < ADDR_LINK_MODE_SELECT || addr > ADDR_LINK_CONTROL) |-> rdata == 8'h00;
    endproperty
    property p_ctl_rsvd; ack && !wr && addr == ADDR_LINK_CONTROL |-> rdata[7:5] == 3'h0; endproperty
    property p_soft_rsvd; ack && !wr && addr == ADDR_SOFT_SYNC_REQUEST |-> rdata[7:1] == 7'h00; endproperty
    // Both mode checks look at the edge on which the write is taken, not at the acknowledge.
    property p_refused;
        req && !ack && wr && addr == ADDR_LINK_MODE_SELECT && !mode_allowed[wdata] |=> $stable(link_mode_select);
    endproperty
    property p_write_lands;
        req && !ack && wr && addr == ADDR_LINK_MODE_SELECT && mode_allowed[wdata] |=> link_mode_select == $past(wdata);
    endproperty
    a_answer: assert property (p_answer) else $error("ack did not follow request");
    a_hold: assert property (p_hold) else $error("request changed while waiting");
    a_leave_reset: assert property (p_leave_reset) else $error("bad state leaving reset");
    a_disabled: assert property (p_disabled) else $error("disabled link not held");
    a_lanes: assert property (p_lanes) else $error("bad lane pattern");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control reserved bits set");
    a_soft_rsvd: assert property (p_soft_rsvd) else $error("sync reserved bits set");
    a_refused: assert property (p_refused) else $error("forbidden mode taken");
    a_write_lands: assert property (p_write_lands) else $error("allowed mode not stored");
endmodule

// ==== testbench/test_serial_link_config_regs.sv ====
// Self-checking bench for the link controller and device joined over their register port.
`timescale 1ns/10ps
module test_serial_link_config_regs
    import link_cfg_pkg::*;
;
    logic         clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rd_chk = 1'b0, probe = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0000_0000, prdata, rdv, seed = 32'h5855_dae1;
    logic         pready, link_en = 1'b0, prim_n = 1'b1, ts_n = 1'b1, cal_en = 1'b0;
    logic [255:0] allow, is64;
    logic [7:0]   lmode, la, lb;
    logic [8:0]   frames;
    logic         fmt, scrambler_enable, syncr, held;
    logic [31:0]  exp_q[$];
    int           miscompares = 0, cmp_count = 0;

    // Free-running system clock.
    always #5 clk = ~clk;

    link_cfg_if lc();
    link_cfg_host link_cfg_host_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .link_enable(link_en), .calibration_enable(cal_en), .cfg(lc.host));
    link_cfg_device link_cfg_device_inst (.clk(clk), .sys_rst(sys_rst), .cfg(lc.device), .mode_allowed(allow),
        .mode_is_64b66b(is64), .mode_e(8'h01), .mode_f(8'h02), .link_enable(link_en),
        .primary_sync_pin_n(prim_n), .timestamp_pin_n(ts_n), .link_mode_select(lmode),
        .frames_per_multiframe(frames), .sample_format(fmt), .scramble_active(scrambler_enable), .sync_request(syncr),
        .link_a_lane_on(la), .link_b_lane_on(lb), .link_held_reset(held));
    link_cfg_checker link_cfg_checker_inst (.clk(clk), .sys_rst(sys_rst), .req(lc.req), .wr(lc.wr),
        .addr(lc.addr), .wdata(lc.wdata), .ack(lc.ack), .rdata(lc.rdata), .link_enable(link_en),
        .mode_allowed(allow), .link_mode_select(lmode), .frames_per_multiframe(frames),
        .link_a_lane_on(la), .link_b_lane_on(lb), .link_held_reset(held));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] g);
        logic [31:0] e;
        e = exp_q.pop_front();
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic chk);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; rd_chk <= chk;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        psel <= 1'b0; penable <= 1'b0; rd_chk <= 1'b0;
    endtask

    // Device access through the controller, polling busy until it clears.
    task automatic dev(input logic w, input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, APB_ADDR, {20'h0_0000, a}, 1'b0);
        apb(1'b1, APB_WDATA, {24'h00_0000, d}, 1'b0);
        apb(1'b1, APB_CTRL, {30'h0000_0000, w, 1'b1}, 1'b0);
        do apb(1'b0, APB_STATUS, 32'h0000_0000, 1'b0); while (rdv[8] !== 1'b0);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        dev(1'b0, a, 8'h00);
        exp_q.push_back({24'h00_0000, e});
        apb(1'b0, APB_STATUS, 32'h0000_0000, 1'b1);
    endtask

    task automatic prb(input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk) probe <= 1'b1;
        @(posedge clk) probe <= 1'b0;
    endtask

    // Results are taken against the oldest note as soon as they appear.
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && rd_chk) cmp(prdata);
        if (probe) cmp({3'h0, lmode, frames, fmt, scrambler_enable, syncr, held, la});
    end

    // Cuts a hang short; the whole run needs far fewer cycles.
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        conclude();
    end

    initial begin
        logic [31:0] r;
        logic [7:0]  ctl, km;
        logic        sync;
        logic [7:0]  rv [4];
        rv = '{RST_LINK_MODE_SELECT, RST_FRAMES_PER_MF_M1, RST_SOFT_SYNC_REQUEST, RST_LINK_CONTROL};
        allow = '1;
        allow[7] = 1'b0;
        is64 = '0;
        is64[5] = 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rv[i]) rdchk(ADDR_LINK_MODE_SELECT + 12'(i), rv[i]);
        rdchk(12'h205, 8'h00);
        // Every sync source, both software request levels, random pins and fields.
        for (int s = 0; s < 8; s++) begin
            link_en <= 1'b0;
            r = rnd();
            ctl = {r[7:5], r[4], 2'(s), r[1:0]};
            km = r[15:8];
            dev(1'b1, ADDR_LINK_CONTROL, ctl);
            dev(1'b1, ADDR_FRAMES_PER_MF_M1, km);
            dev(1'b1, ADDR_SOFT_SYNC_REQUEST, {7'h00, s[2]});
            rdchk(ADDR_LINK_CONTROL, ctl & CTL_WRITE_MASK);
            rdchk(ADDR_FRAMES_PER_MF_M1, km);
            prim_n <= r[20];
            ts_n <= r[21];
            link_en <= 1'b1;
            repeat (4) @(posedge clk);
            sync = !s[2] || (s[1:0] == 2'h0 && !r[20]) || (s[1:0] == 2'h1 && !r[21]);
            prb({3'h0, RST_LINK_MODE_SELECT, 9'(km) + 9'h001, ctl[1], ctl[0], sync, 1'b0,
                ctl[4] ? 8'hf0 : 8'h0f});
        end
        // A 64b/66b mode, then a forbidden mode that must leave it in place.
        link_en <= 1'b0;
        dev(1'b1, ADDR_LINK_MODE_SELECT, 8'h05);
        dev(1'b1, ADDR_LINK_MODE_SELECT, 8'h07);
        rdchk(ADDR_LINK_MODE_SELECT, 8'h05);
        dev(1'b1, ADDR_LINK_CONTROL, 8'h08);
        dev(1'b1, ADDR_SOFT_SYNC_REQUEST, 8'h01);
        link_en <= 1'b1;
        repeat (4) @(posedge clk);
        prb({3'h0, 8'h05, 9'h080, 1'b0, 1'b1, 1'b0, 1'b0, 8'h0f});
        // Guarded writes: frame count with the link up, then mode with calibration on; both refused.
        dev(1'b1, ADDR_FRAMES_PER_MF_M1, 8'h00);
        exp_q.push_back(32'h0000_0201);
        apb(1'b0, APB_STATUS, 32'h0000_0000, 1'b1);
        link_en <= 1'b0;
        cal_en <= 1'b1;
        dev(1'b1, ADDR_LINK_MODE_SELECT, 8'h02);
        exp_q.push_back(32'h0000_0201);
        apb(1'b0, APB_STATUS, 32'h0000_0000, 1'b1);
        rdchk(ADDR_LINK_MODE_SELECT, 8'h05);
        rdchk(ADDR_FRAMES_PER_MF_M1, km);
        conclude();
    end
endmodule
